/* File: verilog/rsu_pkg.sv */
package rsu_pkg;

  // Control and update register layout
  localparam int CTRL_W          = 39;
  localparam int CTRL_WD_LSB     = 0;   // Watchdog time-out upper bits 11:0
  localparam int CTRL_WD_W       = 12;
  localparam int CTRL_ADDR_LSB   = 12;  // Boot address upper bits 33:12
  localparam int CTRL_ADDR_W     = 22;
  localparam int CTRL_RSV1_BIT   = 34;
  localparam int CTRL_WDEN_BIT   = 35;
  localparam int CTRL_OSC_BIT    = 36;
  localparam int CTRL_EARLY_BIT  = 37;
  localparam int CTRL_RSV2_BIT   = 38;

  // Value after reset: boot address zero selects the factory image
  localparam logic [38:0] CTRL_RESET = 39'h78_0000_0000;

  // Fixed low parts appended to the stored upper bits
  localparam logic [16:0] WD_LOW_PATTERN = 17'h00008;
  localparam logic [1:0]  ADDR_LOW_ZERO  = 2'h0;

  // Status word layout
  localparam int ST_MS_HI     = 31;  // Master state 31:30 in current words
  localparam int ST_MS_LO     = 30;
  localparam int ST_WDEN_BIT  = 29;
  localparam int ST_PAD_W     = 6;   // Zero padding 29:24
  localparam int ADDR_W       = 24;
  localparam int WD_W         = 29;

  // Previous-state record layout
  localparam int REC_W        = 31;
  localparam int REC_SRC_LSB  = 26;  // One-hot source 30:26
  localparam int REC_SRC_W    = 5;
  localparam int REC_MS_LSB   = 24;  // Master state 25:24

  // Source positions inside the one-hot field, highest wins
  localparam int SRC_EXT_RESET = 4;
  localparam int SRC_CRC       = 3;
  localparam int SRC_ERR_LINE  = 2;
  localparam int SRC_WATCHDOG  = 1;
  localparam int SRC_FABRIC    = 0;

  // Master state codes
  localparam logic [1:0] MS_FACTORY     = 2'h0;
  localparam logic [1:0] MS_APPLICATION = 2'h1;

  // Capture selector codes
  localparam logic [2:0] SEL_INFO1 = 3'h0;
  localparam logic [2:0] SEL_INFO2 = 3'h1;
  localparam logic [2:0] SEL_PREV1 = 3'h2;
  localparam int         SEL_W     = 3;
  localparam logic [2:0] SEL_PREV2 = 3'h3;
  localparam logic [2:0] SEL_CTRL  = 3'h4;

  // Fabric request hold time, informative for the far side
  localparam int REQ_HOLD_NS   = 250;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REQ_HOLD_CYC  = (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reconfiguration sequencer
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_STATUS,
    RS_CONTROL
  } rsu_seq_t;

endpackage : rsu_pkg

/* File: verilog/rsu_shift_if.sv */
`timescale 1ns/1ps
interface rsu_shift_if;
  import rsu_pkg::*;
  logic              load;       // One-cycle pulse: take load_word
  logic [CTRL_W-1:0] load_word;  // Word captured on load
  logic              shift;      // One-cycle pulse: shift one bit
  logic              din;        // Serial bit entering at the top
  logic [CTRL_W-1:0] word;       // Present shift register contents
  logic              dout;       // Serial bit leaving at the bottom

  modport ctrl    (output load, output load_word, output shift, output din, input word, input dout);
  modport shifter (input load, input load_word, input shift, input din, output word, output dout);
endinterface : rsu_shift_if

/* File: verilog/rsu_shift_reg.sv */
`timescale 1ns/1ps
module rsu_shift_reg
  import rsu_pkg::*;
#(
  parameter int WIDTH = CTRL_W
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Shift control from the status block
  rsu_shift_if.shifter sh
);

  // Wider or narrower words would not hold the control layout
  if (WIDTH != CTRL_W) begin : g_width_check
    $error("rsu_shift_reg: WIDTH must equal CTRL_W");
  end

  typedef struct packed {
    logic [WIDTH-1:0] word;  // Shift register contents
  } rsu_shst_t;

  rsu_shst_t s_q;  // Registered state
  rsu_shst_t s_d;  // Next state

  // Load wins over shift so a capture never mixes old and new bits
  always_comb begin
    s_d = s_q;
    if (sh.load) begin
      s_d.word = sh.load_word;
    end else if (sh.shift) begin
      s_d.word = {sh.din, s_q.word[WIDTH-1:1]};
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the register
  assign sh.word = s_q.word;
  assign sh.dout = s_q.word[0];

endmodule : rsu_shift_reg

/* File: verilog/rsu_status_reconfig.sv */
`timescale 1ns/1ps
// How it works
// - Status records which trigger caused reconfiguration
// - Factory word: state, zero pad, boot address
// - Application word one: state, enable, time-out
// - Application word two: state, pad, boot address
// - Word choice follows factory or application state
// - Two history records: current, then previous application
// - One-hot source field in bits 30:26
// - Simultaneous sources: highest bit position wins
// - Record holds state 25:24, address 23:0
// - Early history capture shifts out invalid marker
// - Update changes only in factory; control changes on any trigger
// - Fabric writes update; sequencer writes control
// - Request rise copies update, starts reconfiguration
// - Error triggers clear control; request loads update
// - Status updated before factory loading starts
// - Control register is 39 bits, fixed layout
// - Time-out and address built from stored bits
// - Capture loads selected status into shifter
module rsu_status_reconfig
  import rsu_pkg::*;
#(
  parameter logic [31:0] INVALID_CAPTURE = 32'hDEAD_0BAD,  // Arbitrary marker value
  parameter int          SYNC_STAGES     = 2
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Fabric shift port, all on the upgrade shift clock
  input  wire logic              upgrade_shift_clock_i,
  input  wire logic              shift_data_i,
  input  wire logic              shift_enable_i,
  input  wire logic              capture_i,
  input  wire logic              update_i,
  input  wire logic [SEL_W-1:0]  capture_select_i,
  output logic                   shift_data_o,
  // Reconfiguration triggers
  input  wire logic              fabric_reconfig_request_i,
  input  wire logic              external_config_reset_n_i,
  input  wire logic              config_error_line_n_i,
  input  wire logic              crc_error_i,
  input  wire logic              watchdog_timeout_i,
  // Reconfiguration outputs
  output logic                   reconfig_start_o,
  output logic [1:0]             master_state_o,
  output logic [ADDR_W-1:0]      boot_address_o,
  output logic                   watchdog_enable_bit_o,
  output logic [WD_W-1:0]        watchdog_timeout_o,
  output logic                   early_done_check_option_o,
  output logic                   osc_clock_option_o
);

  // Only a two-flop synchroniser is built here
  if (SYNC_STAGES != 2) begin : g_sync_check
    $error("rsu_status_reconfig: SYNC_STAGES must be 2");
  end

  typedef struct packed {
    logic [1:0]             clk_s;     // Shift clock synchroniser
    logic [1:0]             dat_s;     // Serial data synchroniser
    logic [1:0]             shen_s;    // Shift enable synchroniser
    logic [1:0]             cap_s;     // Capture synchroniser
    logic [1:0]             upd_s;     // Update synchroniser
    logic [SEL_W-1:0]       sel_s1;    // Selector, first stage
    logic [SEL_W-1:0]       sel_s2;    // Selector, second stage
    logic [1:0]             req_s;     // Fabric request synchroniser
    logic [1:0]             ncfg_s;    // External reset synchroniser
    logic [1:0]             nst_s;     // Error line synchroniser
    logic                   clk_prev;  // Last synced shift clock
    logic                   req_prev;  // Last synced request
    logic                   ncfg_prev; // Last synced external reset
    logic                   nst_prev;  // Last synced error line
    logic [CTRL_W-1:0]      control;   // Active control register
    logic [CTRL_W-1:0]      update;    // Staged update register
    logic [1:0]             ms;        // Master state
    rsu_seq_t               seq;       // Reconfiguration sequencer
    logic [REC_SRC_W-1:0]   src;       // Latched winning source
    logic [REC_W-1:0]       prev1;     // History record one
    logic [REC_W-1:0]       prev2;     // History record two
    logic                   app_seen;  // Application entered once
    logic                   start;     // Reconfiguration start pulse
  } rsu_state_t;

  rsu_state_t s_q;  // Registered state
  rsu_state_t s_d;  // Next state

  rsu_shift_if sh ();  // Link to the shift register

  // Keep only the highest pending source
  function automatic logic [REC_SRC_W-1:0] pick_source(input logic [REC_SRC_W-1:0] raw);
    logic [REC_SRC_W-1:0] hot;
    hot = '0;
    for (int i = 0; i < REC_SRC_W; i++) begin
      if (raw[i]) begin
        hot = '0;
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : pick_source

  // Boot address of a control image
  function automatic logic [ADDR_W-1:0] boot_of(input logic [CTRL_W-1:0] c);
    return {c[CTRL_ADDR_LSB +: CTRL_ADDR_W], ADDR_LOW_ZERO};
  endfunction : boot_of

  // Watchdog time-out of a control image
  function automatic logic [WD_W-1:0] timeout_of(input logic [CTRL_W-1:0] c);
    return {c[CTRL_WD_LSB +: CTRL_WD_W], WD_LOW_PATTERN};
  endfunction : timeout_of

  logic [REC_SRC_W-1:0] raw_src;     // Trigger events this cycle
  logic [31:0]          word_boot;   // Factory word or application word two
  logic [31:0]          word_info1;  // Application word one
  logic [31:0]          cap_word;    // Word chosen for capture
  logic                 clk_rise;    // Shift clock rising edge

  // Trigger events and current-state words
  always_comb begin
    raw_src                = '0;
    raw_src[SRC_EXT_RESET] = s_q.ncfg_prev & ~s_q.ncfg_s[1];
    raw_src[SRC_CRC]       = crc_error_i;
    raw_src[SRC_ERR_LINE]  = s_q.nst_prev & ~s_q.nst_s[1];
    raw_src[SRC_WATCHDOG]  = watchdog_timeout_i;
    raw_src[SRC_FABRIC]    = s_q.req_s[1] & ~s_q.req_prev;
    // Factory word and application word two share one layout
    word_boot  = {s_q.ms, {ST_PAD_W{1'b0}}, boot_of(s_q.control)};
    word_info1 = {s_q.ms, s_q.control[CTRL_WDEN_BIT], timeout_of(s_q.control)};
    clk_rise   = s_q.clk_s[1] & ~s_q.clk_prev;
  end

  // Capture selection; factory state always shows its single word
  always_comb begin
    cap_word = '0;
    unique case (s_q.sel_s2)
      SEL_INFO1: begin
        cap_word = (s_q.ms == MS_APPLICATION) ? word_info1 : word_boot;
      end
      SEL_INFO2: begin
        cap_word = word_boot;
      end
      SEL_PREV1: begin
        cap_word = s_q.app_seen ? {1'b0, s_q.prev1} : INVALID_CAPTURE;
      end
      SEL_PREV2: begin
        cap_word = s_q.app_seen ? {1'b0, s_q.prev2} : INVALID_CAPTURE;
      end
      default: begin
        // Unused codes read as zero; the control image is loaded separately
        cap_word = 32'h0000_0000;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Synchronisers: first stage feeds only the second
    s_d.clk_s  = {s_q.clk_s[0], upgrade_shift_clock_i};
    s_d.dat_s  = {s_q.dat_s[0], shift_data_i};
    s_d.shen_s = {s_q.shen_s[0], shift_enable_i};
    s_d.cap_s  = {s_q.cap_s[0], capture_i};
    s_d.upd_s  = {s_q.upd_s[0], update_i};
    s_d.sel_s1 = capture_select_i;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.req_s  = {s_q.req_s[0], fabric_reconfig_request_i};
    s_d.ncfg_s = {s_q.ncfg_s[0], external_config_reset_n_i};
    s_d.nst_s  = {s_q.nst_s[0], config_error_line_n_i};
    s_d.clk_prev  = s_q.clk_s[1];
    s_d.req_prev  = s_q.req_s[1];
    s_d.ncfg_prev = s_q.ncfg_s[1];
    s_d.nst_prev  = s_q.nst_s[1];
    s_d.start     = 1'b0;

    // Fabric writes the update register, factory only, never mid-sequence
    if (clk_rise && s_q.upd_s[1] && (s_q.ms == MS_FACTORY) && (s_q.seq == RS_IDLE)) begin
      s_d.update = sh.word;
    end

    // Reconfiguration sequencer; triggers during a sequence are dropped
    unique case (s_q.seq)
      RS_IDLE: begin
        if (|raw_src) begin
          s_d.src = pick_source(raw_src);
          s_d.seq = RS_STATUS;
        end
      end
      RS_STATUS: begin
        // History moves before any new image is selected
        if (s_q.ms == MS_APPLICATION) begin
          s_d.prev2 = s_q.prev1;
          s_d.prev1 = {s_q.src, s_q.ms, boot_of(s_q.control)};
        end
        s_d.seq = RS_CONTROL;
      end
      RS_CONTROL: begin
        if (s_q.src[SRC_FABRIC]) begin
          s_d.control  = s_q.update;
          s_d.ms       = MS_APPLICATION;
          s_d.app_seen = 1'b1;
        end else begin
          s_d.control = '0;
          s_d.ms      = MS_FACTORY;
        end
        s_d.start = 1'b1;
        s_d.seq   = RS_IDLE;
      end
    endcase
  end

  // Shift register drive; capture takes priority over shifting
  always_comb begin
    sh.load      = clk_rise & s_q.cap_s[1];
    sh.shift     = clk_rise & ~s_q.cap_s[1] & s_q.shen_s[1];
    sh.din       = s_q.dat_s[1];
    sh.load_word = {{(CTRL_W - 32){1'b0}}, cap_word};
    if (s_q.sel_s2 == SEL_CTRL) begin
      // Factory reads staged settings, application reads active ones
      sh.load_word = (s_q.ms == MS_FACTORY) ? s_q.update : s_q.control;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q          <= '0;
      s_q.clk_s    <= 2'h0;
      s_q.ncfg_s   <= 2'h3;
      s_q.nst_s    <= 2'h3;
      s_q.ncfg_prev <= 1'b1;
      s_q.nst_prev <= 1'b1;
      s_q.control  <= CTRL_RESET;
      s_q.update   <= CTRL_RESET;
      s_q.ms       <= MS_FACTORY;
      s_q.seq      <= RS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Serial shifter
  rsu_shift_reg #(
    .WIDTH (CTRL_W)
  ) u_shift (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .sh        (sh.shifter)
  );

  // Outputs from registers
  assign shift_data_o              = sh.dout;
  assign reconfig_start_o          = s_q.start;
  assign master_state_o            = s_q.ms;
  assign boot_address_o            = boot_of(s_q.control);
  assign watchdog_enable_bit_o     = s_q.control[CTRL_WDEN_BIT];
  assign watchdog_timeout_o        = timeout_of(s_q.control);
  assign early_done_check_option_o = s_q.control[CTRL_EARLY_BIT];
  assign osc_clock_option_o        = s_q.control[CTRL_OSC_BIT];

endmodule : rsu_status_reconfig

/* File: tb/rsu_status_reconfig_assertions.sv */
`timescale 1ns/1ps
module rsu_status_reconfig_assertions
  import rsu_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Triggers
  input  wire logic              fabric_reconfig_request_i,
  input  wire logic              crc_error_i,
  input  wire logic              watchdog_timeout_i,
  // Reconfiguration outputs
  input  wire logic              reconfig_start_o,
  input  wire logic [1:0]        master_state_o,
  input  wire logic [ADDR_W-1:0] boot_address_o,
  input  wire logic              watchdog_enable_bit_o,
  input  wire logic [WD_W-1:0]   watchdog_timeout_o,
  input  wire logic              early_done_check_option_o,
  input  wire logic              osc_clock_option_o
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Start that answers a same-clock error pulse three cycles back
  sequence s_crc_start;
    reconfig_start_o && $past(crc_error_i, 3);
  endsequence
  // Boot address, enable and option bits cleared
  sequence s_cleared;
    boot_address_o == '0 && !watchdog_enable_bit_o && !early_done_check_option_o && !osc_clock_option_o;
  endsequence
  // Start that enters the application image
  sequence s_start_app;
    reconfig_start_o && master_state_o == MS_APPLICATION;
  endsequence

  property p_crc_clears;
    s_crc_start |-> s_cleared;
  endproperty
  property p_wd_factory;
    reconfig_start_o && $past(watchdog_timeout_i, 3) |-> master_state_o == MS_FACTORY
      && watchdog_timeout_o == {12'h000, WD_LOW_PATTERN};
  endproperty
  // Pin is synchronised, so the window allows for its phase
  property p_req_app;
    $rose(fabric_reconfig_request_i) |-> ##[3:7] s_start_app;
  endproperty
  // Sequencer is busy two cycles, so no start follows within two
  property p_start_pulse;
    reconfig_start_o |=> !reconfig_start_o [*2];
  endproperty
  property p_wd_low;
    watchdog_timeout_o[16:0] == WD_LOW_PATTERN;
  endproperty
  property p_addr_low;
    boot_address_o[1:0] == ADDR_LOW_ZERO;
  endproperty
  // Control only moves with the sequencer's start
  property p_ctrl_hold;
    !reconfig_start_o |-> $stable(boot_address_o) && $stable(master_state_o) && $stable(watchdog_enable_bit_o);
  endproperty

  a_crc_clears: assert property (p_crc_clears) else $error("crc trigger left control set");
  a_wd_factory: assert property (p_wd_factory) else $error("watchdog trigger not to factory");
  a_req_app: assert property (p_req_app) else $error("fabric request did not start application");
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_wd_low: assert property (p_wd_low) else $error("timeout low part wrong");
  a_addr_low: assert property (p_addr_low) else $error("boot address low bits set");
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without trigger");
endmodule : rsu_status_reconfig_assertions

bind rsu_status_reconfig rsu_status_reconfig_assertions u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .fabric_reconfig_request_i(fabric_reconfig_request_i),
  .crc_error_i(crc_error_i), .watchdog_timeout_i(watchdog_timeout_i), .reconfig_start_o(reconfig_start_o),
  .master_state_o(master_state_o), .boot_address_o(boot_address_o), .watchdog_enable_bit_o(watchdog_enable_bit_o),
  .watchdog_timeout_o(watchdog_timeout_o), .early_done_check_option_o(early_done_check_option_o),
  .osc_clock_option_o(osc_clock_option_o));

/* File: tb/rsu_fabric_model.sv */
`timescale 1ns/1ps
module rsu_fabric_model;
  // Fabric shift port, clock stands low outside frames
  logic       sclk_o = 1'b0;
  logic       sdata_o = 1'b0;
  logic       sen_o = 1'b0;
  logic       cap_o = 1'b0;
  logic       upd_o = 1'b0;
  logic [2:0] sel_o = 3'h0;
  logic       req_o = 1'b0;   // Reconfiguration request
  logic       sout_i;         // Serial answer, driven by the bench

  // One 80 ns shift clock period; inputs change only while low
  task automatic tick;
    #40 sclk_o = 1'b1;
    #40 sclk_o = 1'b0;
  endtask : tick

  // Capture one word and shift it out, bit 0 first
  task automatic capture_word(input logic [2:0] sel, output logic [38:0] w);
    #3.3;               // Keeps the link off the core clock phase
    cap_o = 1'b1;
    sel_o = sel;
    tick();
    cap_o = 1'b0;
    sen_o = 1'b1;
    for (int i = 0; i < 39; i++) begin
      #40 w[i] = sout_i;  // Sampled late, long after the output settled
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    sen_o = 1'b0;
    sel_o = ~sel;       // Released lines do not keep their last value
  endtask : capture_word

  // Shift a full 39-bit word then write the update register
  task automatic write_update(input logic [38:0] v);
    #3.3;
    sen_o = 1'b1;
    for (int i = 0; i < 39; i++) begin
      sdata_o = v[i];
      tick();
    end
    sen_o = 1'b0;
    upd_o = 1'b1;
    tick();
    upd_o = 1'b0;
    sdata_o = ~sdata_o;
  endtask : write_update

  // Request held longer than the minimum hold
  task automatic request;
    req_o = 1'b1;
    #300 req_o = 1'b0;
  endtask : request
endmodule : rsu_fabric_model

/* File: tb/rsu_status_reconfig_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module rsu_status_reconfig_bench;
  import rsu_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              crc_i = 1'b0;
  logic              wdt_i = 1'b0;
  logic              ncfg_n = 1'b1;  // External reset pin, idle high
  logic              nst_n = 1'b1;   // Error line pin, idle high
  logic              sout, start, wden, early, osc;
  logic [1:0]        ms;
  logic [ADDR_W-1:0] boot;
  logic [WD_W-1:0]   tmo;
  logic [38:0]       w;
  int                error_cnt = 0;
  int                tests_run = 0;
  // Update word: wd 0xA5C, address 0x12345, enable and early on, osc off
  localparam logic [38:0] UPD = {1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 22'h12345, 12'hA5C};
  localparam logic [23:0] UPD_BOOT = 24'h048D14;

  always #5 ref_clk_i = ~ref_clk_i;

  rsu_fabric_model fab ();
  assign fab.sout_i = sout;
  // Active-low pins idle high until the pin scenario pulls them
  rsu_status_reconfig dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .upgrade_shift_clock_i(fab.sclk_o), .shift_data_i(fab.sdata_o),
    .shift_enable_i(fab.sen_o), .capture_i(fab.cap_o), .update_i(fab.upd_o), .capture_select_i(fab.sel_o),
    .shift_data_o(sout), .fabric_reconfig_request_i(fab.req_o), .external_config_reset_n_i(ncfg_n),
    .config_error_line_n_i(nst_n), .crc_error_i(crc_i), .watchdog_timeout_i(wdt_i), .reconfig_start_o(start),
    .master_state_o(ms), .boot_address_o(boot), .watchdog_enable_bit_o(wden), .watchdog_timeout_o(tmo),
    .early_done_check_option_o(early), .osc_clock_option_o(osc));

  // Bounded wait for the one-cycle start pulse
  task automatic wait_start;
    int n;
    n = 0;
    while (start !== 1'b1 && n < 40) begin
      @(posedge ref_clk_i) #1;
      n++;
    end
    `CHK("start", 1'b1, start)
  endtask : wait_start

  // Same-clock error pulse, one cycle wide
  task automatic pulse_err(input logic c, input logic d);
    @(posedge ref_clk_i) #1;
    crc_i = c;
    wdt_i = d;
    @(posedge ref_clk_i) #1;
    crc_i = 1'b0;
    wdt_i = 1'b0;
    wait_start();
  endtask : pulse_err

  task automatic t_reset_values;
    `CHK("reset control", {ms, boot, wden, tmo, early, osc}, {2'h0, 24'h0, 1'b1, 29'h8, 1'b1, 1'b1})
    fab.capture_word(SEL_INFO1, w);
    `CHK("factory word", w, 39'h0)
    fab.capture_word(SEL_PREV1, w);
    `CHK("early history", w, {7'h0, 32'hDEAD_0BAD})
  endtask : t_reset_values

  task automatic t_load_update;
    fab.write_update(UPD);
    fab.capture_word(SEL_CTRL, w);
    `CHK("update reg", w, UPD)
  endtask : t_load_update

  task automatic t_request_app;
    fork
      fab.request();
      wait_start();
    join
    `CHK("app control", {ms, boot, wden, tmo, early, osc}, {2'h1, UPD_BOOT, 1'b1, 12'hA5C, 17'h8, 1'b1, 1'b0})
    fab.capture_word(SEL_INFO1, w);
    `CHK("app word one", w, {7'h0, 2'h1, 1'b1, 12'hA5C, 17'h8})
    fab.capture_word(SEL_INFO2, w);
    `CHK("app word two", w, {7'h0, 2'h1, 6'h0, UPD_BOOT})
  endtask : t_request_app

  task automatic t_watchdog_clear;
    fab.write_update(39'h0);  // Refused in application
    pulse_err(1'b0, 1'b1);
    `CHK("cleared control", {ms, boot, wden, tmo, early, osc}, {2'h0, 24'h0, 1'b0, 29'h8, 1'b0, 1'b0})
    fab.capture_word(SEL_INFO1, w);
    `CHK("factory again", w, 39'h0)
  endtask : t_watchdog_clear

  task automatic t_priority;
    fork
      fab.request();
      wait_start();
    join
    `CHK("kept update", boot, UPD_BOOT)
    pulse_err(1'b1, 1'b1);
    fab.capture_word(SEL_PREV1, w);
    `CHK("history one", w, {8'h0, 5'b01000, 2'h1, UPD_BOOT})
    fab.capture_word(SEL_PREV2, w);
    `CHK("history two", w, {8'h0, 5'b00010, 2'h1, UPD_BOOT})
  endtask : t_priority

  // Both pins fall together while in application: external reset must win
  task automatic t_pins;
    fork
      fab.request();
      wait_start();
    join
    @(posedge ref_clk_i) #1;
    ncfg_n = 1'b0;
    nst_n  = 1'b0;
    wait_start();
    `CHK("pin cleared control", {ms, boot, wden, early, osc}, {2'h0, 24'h0, 1'b0, 1'b0, 1'b0})
    ncfg_n = 1'b1;
    nst_n  = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    fab.capture_word(SEL_PREV1, w);
    `CHK("pin history one", w, {8'h0, 5'b10000, 2'h1, UPD_BOOT})
    fab.capture_word(SEL_PREV2, w);
    `CHK("pin history two", w, {8'h0, 5'b01000, 2'h1, UPD_BOOT})
  endtask : t_pins

  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Watchdog well past the expected 40 us of traffic
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    t_reset_values();
    t_load_update();
    t_request_app();
    t_watchdog_clear();
    t_priority();
    t_pins();
    final_report();
  end
endmodule : rsu_status_reconfig_bench
